// File: verilog/usb_dev_mode_hw_config_regs.sv
// Mode and hardware configuration registers with their command port and derived controls.
// How it works
// - Command b8 writes the one-byte mode register, b9 reads it.
// - On a 16-bit host bus the upper byte of a mode write is dropped.
// - Mode bit 7 selects 16-bit DMA when one, 8-bit when zero.
// - Suspend starts only after bit 5 is written one and then zero.
// - Mode bit 3 gates every interrupt; zero holds all interrupts off.
// - Debug mode bit 2 makes every NAK and error raise an interrupt.
// - Otherwise bulk ACKs and completed isochronous transfers raise interrupts.
// - Mode bit 0 connects the pull-up, ignored when external pull-up is selected.
// - Mode register clears at power-on; bus reset keeps its stored bits.
// - Command ba writes and bb reads the two-byte hardware configuration.
// - Low byte holds device and pin control, high byte the clock controls and the external pull-up select.
// - Bus reset never changes the hardware configuration register.
// - Configuration drives connection, suspend clocks, clock divider, DMA mode, pins.
// - External pull-up selection keeps the internal switched pull-up off.
// - Output clock is 48 MHz over divider plus one, switched without glitches.
// - Handshake bit one selects acknowledge-only DMA, zero the classic handshake.
// - Interrupt output is a level, or a pulse of one 100 ns clock cycle (166 ns rounded down).
module usb_dev_mode_hw_config_regs
    import mode_cfg_pkg::*;
(
    input  wire logic        CLK,
    input  wire logic        RESETN,
    input  wire logic        BUS_RESET,
    input  wire logic        BUS16,
    input  wire logic        CMD_VALID,
    input  wire logic [7:0]  CMD_CODE,
    input  wire logic        WR_VALID,
    input  wire logic [15:0] WR_DATA,
    input  wire logic        RD_REQ,
    output logic      [15:0] RD_DATA,
    input  wire logic        EV_ACK,
    input  wire logic        EV_XFER_DONE,
    input  wire logic        EV_NAK,
    input  wire logic        EV_ERROR,
    input  wire logic        EV_ISO,
    input  wire logic        EV_OTHER,
    input  wire logic        CLK48_EN,
    output logic             INT_OUT,
    output logic             SUSPEND_REQ,
    output logic             PULLUP_ON,
    output logic             DMA_WIDE,
    output logic             DMA_ACK_ONLY,
    output logic             DREQ_HIGH,
    output logic             DACK_HIGH,
    output logic             EOT_HIGH,
    output logic             WAKE_ON_CS,
    output logic             POWER_OFF_EN,
    output logic             CLOCK_RUN,
    output logic             SLOW_CLK_OFF,
    output logic             CLKOUT_EN
);
    // The command sequencer remembers which register the last code opened and which byte
    // comes next. Any new code closes an unfinished transfer, so a host that gives up half
    // way never leaves a byte pointer behind for the next command. The bus reset input is
    // not read at all, because neither register may be touched by a bus reset.
    typedef enum logic [1:0] {IDLE, MODE_W, CFG_W, CFG_R} cmd_state_t;

    cmd_state_t  state;
    logic        byte_hi;
    logic [7:0]  mode_control;
    logic [15:0] hardware_config;
    logic        trig_prev;
    logic        irq_level;
    logic        irq_prev;
    logic [7:0]  pulse_cnt;
    logic [3:0]  div_active;
    logic [3:0]  div_cnt;
    logic        irq_event;

    // A bus reset is not read by the command sequencer either; it never reaches the stored bits.
    always_ff @(posedge CLK or negedge RESETN) begin
        if (!RESETN) begin
            state   <= IDLE;
            byte_hi <= 1'b0;
        end else if (CMD_VALID) begin
            byte_hi <= 1'b0;
            if (CMD_CODE == CMD_MODE_WR) begin
                state <= MODE_W;
            end else if (CMD_CODE == CMD_HWCFG_WR || CMD_CODE == CMD_HWCFG_RD) begin
                state <= (CMD_CODE == CMD_HWCFG_WR) ? CFG_W : CFG_R;
            end else begin
                state <= IDLE;
            end
        end else if (state == MODE_W && WR_VALID) begin
            state <= IDLE;
        end else if ((state == CFG_W && WR_VALID) || (state == CFG_R && RD_REQ)) begin
            // A 16-bit bus carries both bytes in one word; an 8-bit bus needs two.
            if (BUS16 || byte_hi) begin
                state   <= IDLE;
                byte_hi <= 1'b0;
            end else begin
                byte_hi <= 1'b1;
            end
        end
    end

    // Reserved bits are stored as written, so a read returns exactly what the host put there.
    // Only the power-on reset clears the register; that is the one place it loses its value.
    always_ff @(posedge CLK or negedge RESETN) begin
        if (!RESETN) begin
            mode_control <= MODE_RESET;
        end else if (state == MODE_W && WR_VALID) begin
            mode_control <= WR_DATA[7:0];
        end
    end

    // On an 8-bit host the low byte lands first and is live at once, before the high byte.
    // A host that changes pin polarities should therefore do so while the pins are idle.
    always_ff @(posedge CLK or negedge RESETN) begin
        if (!RESETN) begin
            hardware_config <= HWCFG_RESET;
        end else if (state == CFG_W && WR_VALID) begin
            if (BUS16) begin
                hardware_config <= WR_DATA;
            end else if (byte_hi) begin
                hardware_config[15:8] <= WR_DATA[7:0];
            end else begin
                hardware_config[7:0] <= WR_DATA[7:0];
            end
        end
    end

    always_ff @(posedge CLK or negedge RESETN) begin
        if (!RESETN) begin
            // Read data is captured on the command edge (an 8-bit config high byte on the first read phase), so it stays put while the host reads.
            RD_DATA <= 16'h0000;
        end else if (CMD_VALID && CMD_CODE == CMD_MODE_RD) begin
            RD_DATA <= {8'h00, mode_control};
        end else if (CMD_VALID && CMD_CODE == CMD_HWCFG_RD) begin
            RD_DATA <= BUS16 ? hardware_config : {8'h00, hardware_config[7:0]};
        end else if (state == CFG_R && RD_REQ && !BUS16 && !byte_hi) begin
            RD_DATA <= {8'h00, hardware_config[15:8]};
        end
    end

    // The trigger must fall from a stored one, so a lone zero write does nothing.
    always_ff @(posedge CLK or negedge RESETN) begin
        if (!RESETN) begin
            trig_prev   <= 1'b0;
            SUSPEND_REQ <= 1'b0;
        end else begin
            trig_prev   <= mode_control[MODE_SUSPEND];
            SUSPEND_REQ <= trig_prev && !mode_control[MODE_SUSPEND];
        end
    end

    // Events outside the endpoints interrupt in both modes; debug mode only swaps which
    // endpoint events count, so the event inputs can be wired the same in either mode.
    always_comb begin
        if (mode_control[MODE_DEBUG]) begin
            irq_event = EV_NAK || EV_ERROR || EV_OTHER;
        end else begin
            irq_event = (EV_ISO ? EV_XFER_DONE : EV_ACK) || EV_OTHER;
        end
    end

    always_ff @(posedge CLK or negedge RESETN) begin
        if (!RESETN) begin
            irq_level <= 1'b0;
            irq_prev  <= 1'b0;
            pulse_cnt <= 8'h00;
        end else begin
            irq_level <= irq_event && mode_control[MODE_IRQ_EN];
            irq_prev  <= irq_level;
            if (irq_level && !irq_prev) begin
                pulse_cnt <= 8'(IRQ_PULSE_CYC);
            end else if (pulse_cnt != 8'h00) begin
                pulse_cnt <= pulse_cnt - 8'h01;
            end
        end
    end

    // The pin idles at the inactive level of the configured polarity, also during reset.
    // Pulse mode costs one extra cycle of latency against level mode.
    always_ff @(posedge CLK or negedge RESETN) begin
        if (!RESETN) begin
            INT_OUT <= ~HWCFG_RESET[CFG_IRQ_POL];
        end else begin
            INT_OUT <= (hardware_config[CFG_IRQ_PULSE] ? (pulse_cnt != 8'h00) : irq_level)
                       ~^ hardware_config[CFG_IRQ_POL];
        end
    end

    // The new divider is taken only at the end of a whole output period, so no runt pulse.
    always_ff @(posedge CLK or negedge RESETN) begin
        if (!RESETN) begin
            div_active <= HWCFG_RESET[CFG_DIV_LSB +: 4];
            div_cnt    <= 4'h0;
            CLKOUT_EN  <= 1'b0;
        end else if (CLK48_EN) begin
            CLKOUT_EN <= (div_cnt == 4'h0);
            if (div_cnt >= div_active) begin
                div_cnt    <= 4'h0;
                div_active <= hardware_config[CFG_DIV_LSB +: 4];
            end else begin
                div_cnt <= div_cnt + 4'h1;
            end
        end else begin
            CLKOUT_EN <= 1'b0;
        end
    end

    // The remaining controls are plain register bits that other blocks read directly, except PULLUP_ON, gated by the external pull-up select.
    // They are left combinational since they only change on a host write.
    assign PULLUP_ON    = mode_control[MODE_PULLUP] && !hardware_config[CFG_EXT_PULLUP];
    assign DMA_WIDE     = mode_control[MODE_DMA_WIDTH];
    assign DMA_ACK_ONLY = hardware_config[CFG_ACK_ONLY];
    assign DREQ_HIGH    = hardware_config[CFG_DREQ_POL];
    assign DACK_HIGH    = hardware_config[CFG_DACK_POL];
    assign EOT_HIGH     = hardware_config[CFG_EOT_POL];
    assign WAKE_ON_CS   = hardware_config[CFG_WAKE_CS];
    assign POWER_OFF_EN = hardware_config[CFG_PWR_OFF];
    assign CLOCK_RUN    = hardware_config[CFG_CLK_RUN];
    assign SLOW_CLK_OFF = hardware_config[CFG_NO_SLOW];
endmodule : usb_dev_mode_hw_config_regs

// File: verilog/mode_cfg_pkg.sv
// Command codes, field positions and reset values of the mode and configuration registers.
package mode_cfg_pkg;
    localparam logic [7:0]  CMD_MODE_WR    = 8'hb8;
    localparam logic [7:0]  CMD_MODE_RD    = 8'hb9;
    localparam logic [7:0]  CMD_HWCFG_WR   = 8'hba;
    localparam logic [7:0]  CMD_HWCFG_RD   = 8'hbb;
    localparam int          MODE_DMA_WIDTH = 7;
    localparam int          MODE_SUSPEND   = 5;
    localparam int          MODE_IRQ_EN    = 3;
    localparam int          MODE_DEBUG     = 2;
    localparam int          MODE_PULLUP    = 0;
    localparam logic [7:0]  MODE_RESET     = 8'h00;
    localparam int          CFG_EXT_PULLUP = 14;
    localparam int          CFG_NO_SLOW    = 13;
    localparam int          CFG_CLK_RUN    = 12;
    localparam int          CFG_DIV_LSB    = 8;
    localparam int          CFG_ACK_ONLY   = 7;
    localparam int          CFG_DREQ_POL   = 6;
    localparam int          CFG_DACK_POL   = 5;
    localparam int          CFG_EOT_POL    = 4;
    localparam int          CFG_WAKE_CS    = 3;
    localparam int          CFG_PWR_OFF    = 2;
    localparam int          CFG_IRQ_PULSE  = 1;
    localparam int          CFG_IRQ_POL    = 0;
    localparam logic [15:0] HWCFG_RESET    = 16'h2340;
    localparam int          CLK_PERIOD_NS  = 100;
    localparam int          IRQ_PULSE_NS   = 166;
    // Longest time rounds down, never below one cycle.
    localparam int          IRQ_PULSE_CYC  = (IRQ_PULSE_NS / CLK_PERIOD_NS) < 1 ? 1 :
                                             (IRQ_PULSE_NS / CLK_PERIOD_NS);
endpackage : mode_cfg_pkg

// File: verification/mode_cfg_properties.sv
// Concurrent checks on the mode and configuration register ports.
module mode_cfg_properties
    import mode_cfg_pkg::*;
(
    input logic        CLK,
    input logic        RESETN,
    input logic        BUS_RESET,
    input logic        BUS16,
    input logic        CMD_VALID,
    input logic [7:0]  CMD_CODE,
    input logic        WR_VALID,
    input logic [15:0] WR_DATA,
    input logic [15:0] RD_DATA,
    input logic        SUSPEND_REQ,
    input logic        PULLUP_ON,
    input logic        DMA_WIDE,
    input logic        DMA_ACK_ONLY
);
    timeunit 1ns;
    timeprecision 1ns;
    default clocking cb @(posedge CLK); endclocking
    default disable iff (!RESETN);
    sequence mode_wr;
        CMD_VALID && CMD_CODE == CMD_MODE_WR ##1 WR_VALID;
    endsequence
    sequence cfg_wr16;
        CMD_VALID && CMD_CODE == CMD_HWCFG_WR ##1 WR_VALID && BUS16;
    endsequence
    a_mode_width: assert property (mode_wr |=> DMA_WIDE == $past(WR_DATA[7]))
        else $error("dma width not taken from write");
    a_pullup_off: assert property (mode_wr |=> !PULLUP_ON || $past(WR_DATA[0]))
        else $error("pull-up on while bit is zero");
    a_suspend_once: assert property (SUSPEND_REQ |=> !SUSPEND_REQ)
        else $error("suspend request too long");
    a_suspend_cause: assert property (SUSPEND_REQ |-> $past(WR_VALID, 2))
        else $error("suspend request without write");
    a_read_mode: assert property (CMD_VALID && CMD_CODE == CMD_MODE_RD |=> RD_DATA[7] == DMA_WIDE)
        else $error("mode read mismatch");
    a_read_cfg: assert property (CMD_VALID && CMD_CODE == CMD_HWCFG_RD |=> RD_DATA[7] == DMA_ACK_ONLY)
        else $error("config read mismatch");
    a_cfg_word: assert property (cfg_wr16 |=> DMA_ACK_ONLY == $past(WR_DATA[7]))
        else $error("ack-only mode not taken");
    a_cfg_hold: assert property (!WR_VALID |=> $stable(DMA_ACK_ONLY))
        else $error("config changed without write");
    a_mode_hold: assert property (BUS_RESET && !WR_VALID |=> $stable(DMA_WIDE))
        else $error("bus reset changed mode");
endmodule : mode_cfg_properties
bind usb_dev_mode_hw_config_regs mode_cfg_properties u_props (.*);

// File: verification/host_model.sv
// Microcontroller model issuing commands and data phases.
module host_model (
    input  logic        CLK,
    output logic        CMD_VALID = 1'b0,
    output logic [7:0]  CMD_CODE = 8'h00,
    output logic        WR_VALID = 1'b0,
    output logic [15:0] WR_DATA = 16'h0000,
    output logic        RD_REQ = 1'b0
);
    timeunit 1ns;
    timeprecision 1ns;
    // Two phases carry low byte then high byte; released lines show inverted data.
    task automatic op(input logic [7:0] c, input logic [15:0] d, input int n, input bit rd);
        @(negedge CLK) CMD_VALID = 1;
        CMD_CODE = c;
        for (int i = 0; i < n; i++) begin
            @(negedge CLK) CMD_VALID = 0;
            CMD_CODE = ~c;
            RD_REQ = rd;
            WR_VALID = !rd;
            WR_DATA = n == 2 ? {8'h00, i ? d[15:8] : d[7:0]} : d;
        end
        @(negedge CLK) {CMD_VALID, WR_VALID, RD_REQ} = 3'h0;
        CMD_CODE = ~c;
        WR_DATA = ~WR_DATA;
    endtask : op
endmodule : host_model

// File: verification/testbench.sv
// Self-checking bench for the mode and configuration registers.
module testbench;
    timeunit 1ns;
    timeprecision 1ns;
    import mode_cfg_pkg::*;
    logic CLK = 0, RESETN = 0, BUS_RESET = 0, BUS16 = 1, CMD_VALID, WR_VALID, RD_REQ;
    logic EV_ACK = 0, EV_XFER_DONE = 0, EV_NAK = 0, EV_ERROR = 0, EV_ISO = 0;
    logic EV_OTHER = 0, CLK48_EN = 0, INT_OUT, SUSPEND_REQ, PULLUP_ON, DMA_WIDE;
    logic DMA_ACK_ONLY, DREQ_HIGH, DACK_HIGH, EOT_HIGH, WAKE_ON_CS, POWER_OFF_EN;
    logic CLOCK_RUN, SLOW_CLK_OFF, CLKOUT_EN, rd_seen = 0, en_q = 0, clk_chk = 0;
    logic [7:0] CMD_CODE;
    logic [15:0] WR_DATA, RD_DATA, d;
    logic [16:0] q[$], e;
    int err_count = 0, compares = 0, susp_n = 0;
    usb_dev_mode_hw_config_regs u_dut (.*);
    host_model h (.*);
    always #50 CLK = ~CLK;
    always @(negedge CLK) CLK48_EN <= 1'($urandom);
    always @(negedge CLK) if (SUSPEND_REQ === 1'b1) susp_n++;
    always @(posedge CLK) rd_seen <= RD_REQ || (CMD_VALID && (CMD_CODE == CMD_MODE_RD ||
                                                              CMD_CODE == CMD_HWCFG_RD));
    always @(posedge CLK) en_q <= CLK48_EN;
    task automatic chk(string n, logic [15:0] x, logic [15:0] g);
        compares++;
        if (g !== x) begin
            err_count++;
            $display("CHECK FAILED %s exp %h got %h", n, x, g);
        end
    endtask : chk
    always @(negedge CLK) if (rd_seen && q.size() > 0) begin
        e = q.pop_front();
        chk("read", e[16] ? e[15:0] : e[7:0], e[16] ? RD_DATA : RD_DATA[7:0]);
    end
    // With a divider of zero every reference tick must give one output pulse.
    always @(negedge CLK) if (clk_chk) chk("clkout", en_q, CLKOUT_EN);
    task automatic close_out();
        if (err_count == 0 && compares > 0) $display("== PASSED ==");
        else $display("== FAILED ==");
        $finish;
    endtask : close_out
    // Holds one event for h cycles and records the interrupt pin over the next four cycles.
    task automatic ev_burst(int h, logic nak, logic [3:0] x);
        logic [3:0] s;
        s = 4'h0;
        EV_ACK = !nak;
        EV_NAK = nak;
        for (int i = 1; i <= 4; i++) begin
            @(negedge CLK) s = {s[2:0], INT_OUT};
            if (i == h) {EV_ACK, EV_NAK} = 2'b00;
        end
        chk("irq", x, s);
    endtask : ev_burst
    initial begin
        #300000 err_count++;
        close_out();
    end
    initial begin
        void'($urandom(32'hde50));
        repeat (3) @(negedge CLK);
        RESETN = 1;
        q.push_back({9'h0, MODE_RESET});
        h.op(CMD_MODE_RD, 0, 0, 1);
        q.push_back({1'b1, HWCFG_RESET});
        h.op(CMD_HWCFG_RD, 0, 0, 1);
        repeat (4) begin
            d = 16'($urandom) & 16'hffdf;
            h.op(CMD_MODE_WR, d, 1, 0);
            chk("dma_wide", d[7], DMA_WIDE);
            q.push_back({9'h0, d[7:0]});
            h.op(CMD_MODE_RD, 0, 0, 1);
        end
        h.op(CMD_MODE_WR, 0, 1, 0);
        repeat (3) @(negedge CLK);
        chk("suspend", 0, susp_n);
        h.op(CMD_MODE_WR, 16'h20, 1, 0);
        h.op(CMD_MODE_WR, 0, 1, 0);
        repeat (3) @(negedge CLK);
        chk("suspend", 1, susp_n);
        BUS16 = 0;
        d = 16'($urandom) & 16'hbfff;
        h.op(CMD_HWCFG_WR, d, 2, 0);
        chk("ack_only", d[7], DMA_ACK_ONLY);
        chk("cfg_pins", {d[13:12], d[6:2]}, {SLOW_CLK_OFF, CLOCK_RUN, DREQ_HIGH, DACK_HIGH,
            EOT_HIGH, WAKE_ON_CS, POWER_OFF_EN});
        h.op(CMD_MODE_WR, 16'h01, 1, 0);
        chk("pullup", 1, PULLUP_ON);
        d = d | 16'h4000;
        h.op(CMD_HWCFG_WR, d, 2, 0);
        chk("pullup", 0, PULLUP_ON);
        BUS_RESET = 1;
        repeat (5) @(negedge CLK);
        BUS_RESET = 0;
        q.push_back(17'h1);
        h.op(CMD_MODE_RD, 0, 0, 1);
        q.push_back({9'h0, d[7:0]});
        q.push_back({9'h0, d[15:8]});
        h.op(CMD_HWCFG_RD, 0, 1, 1);
        BUS16 = 1;
        h.op(CMD_HWCFG_WR, 16'h0001, 1, 0);
        repeat (80) @(negedge CLK);
        clk_chk = 1;
        repeat (40) @(negedge CLK);
        clk_chk = 0;
        h.op(CMD_MODE_WR, 0, 1, 0);
        ev_burst(1, 0, 4'b0000);
        h.op(CMD_MODE_WR, 16'h08, 1, 0);
        ev_burst(1, 0, 4'b0100);
        h.op(CMD_MODE_WR, 16'h0c, 1, 0);
        ev_burst(1, 0, 4'b0000);
        ev_burst(1, 1, 4'b0100);
        h.op(CMD_HWCFG_WR, 16'h0003, 1, 0);
        h.op(CMD_MODE_WR, 16'h08, 1, 0);
        ev_burst(3, 0, 4'b0010);
        close_out();
    end
endmodule : testbench
